// [inc/modulo_timer_consts.vh]
// Constants for the 8-bit modulo timer: register offsets, field positions,
// reset values and encodings. Included by the prescaler and top design files of the block.
`ifndef MODULO_TIMER_CONSTS_VH
`define MODULO_TIMER_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets (4-bit address port)
// ----------------------------------------------------------------------
`define MODULO_TIMER_ADDR_W          4
`define MODULO_TIMER_OFS_STATUS_CTRL 4'h0
`define MODULO_TIMER_OFS_CLOCK_CFG   4'h1
`define MODULO_TIMER_OFS_COUNT_VALUE 4'h2
`define MODULO_TIMER_OFS_MODULO      4'h3

// ----------------------------------------------------------------------
// Status/control fields
// ----------------------------------------------------------------------
`define MODULO_TIMER_BIT_OVF_FLAG    7
`define MODULO_TIMER_BIT_OVF_IRQ_EN  6
`define MODULO_TIMER_BIT_CNT_CLEAR   5
`define MODULO_TIMER_BIT_CNT_HALT    4

// ----------------------------------------------------------------------
// Clock configuration fields
// ----------------------------------------------------------------------
`define MODULO_TIMER_SRC_MSB         5
`define MODULO_TIMER_SRC_LSB         4
`define MODULO_TIMER_PS_MSB          3
`define MODULO_TIMER_PS_LSB          0
`define MODULO_TIMER_SRC_BUS         2'h0
`define MODULO_TIMER_SRC_FIXED       2'h1
`define MODULO_TIMER_SRC_EXT_FALL    2'h2
`define MODULO_TIMER_SRC_EXT_RISE    2'h3
`define MODULO_TIMER_PS_MAX          4'h8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MODULO_TIMER_RST_HALT        1'h1
`define MODULO_TIMER_RST_IRQ_EN      1'h0
`define MODULO_TIMER_RST_SRC         2'h0
`define MODULO_TIMER_RST_PS          4'h0
`define MODULO_TIMER_RST_COUNT       8'h00
`define MODULO_TIMER_RST_MODULO      8'h00

`endif

// [rtl/modulo_timer_edge_sync.v]
// Two-flop synchroniser for an asynchronous pin, followed by edge detection.
// Assumes the pin toggles no faster than a quarter of ref_clk_i.
`timescale 1ns/1ps
module modulo_timer_edge_sync (
   // Clock and reset
   input  wire ref_clk_i,
   input  wire rst_i,
   // Pin and edges
   input  wire pin_i,
   output reg  rise_o,
   output reg  fall_o
);

   reg meta;
   reg sync;
   reg sync_d;

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         meta   <= 1'b0;
         sync   <= 1'b0;
         sync_d <= 1'b0;
         rise_o <= 1'b0;
         fall_o <= 1'b0;
      end else begin
         meta   <= pin_i;
         sync   <= meta;
         sync_d <= sync;
         rise_o <= sync & ~sync_d;
         fall_o <= ~sync & sync_d;
      end
   end

endmodule

// [rtl/modulo_timer_prescaler.v]
// Power-of-two prescaler: passes one tick out of every 2**sel source ticks, with sel capped at 8.
// Assumes src_tick_i is a one-cycle pulse on ref_clk_i.
`include "modulo_timer_consts.vh"
`timescale 1ns/1ps
module modulo_timer_prescaler (
   // Clock and reset
   input  wire       ref_clk_i,
   input  wire       rst_i,
   // Control
   input  wire       run_i,
   input  wire [3:0] sel_i,
   input  wire       src_tick_i,
   // Output
   output wire       tick_o
);

   reg  [7:0] div_cnt;
   reg  [7:0] mask;
   wire [3:0] sel_eff;

   // Codes above the last defined one divide by the largest ratio
   assign sel_eff = (sel_i > `MODULO_TIMER_PS_MAX) ? `MODULO_TIMER_PS_MAX : sel_i;

   always @* begin
      mask = 8'hff;
      if (sel_eff < `MODULO_TIMER_PS_MAX)
         mask = (8'h01 << sel_eff[2:0]) - 8'h01;
   end

   // Divider keeps running across ratio changes; the count itself is never touched
   assign tick_o = run_i & src_tick_i & ((div_cnt & mask) == mask);

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         div_cnt <= 8'h00;
      end else if (run_i && src_tick_i) begin
         div_cnt <= div_cnt + 8'h01;
      end
   end

endmodule

// [rtl/modulo_timer_top.v]
// 8-bit modulo timer with prescaler, clock source select and overflow flag.
// Assumes a single-cycle register port on ref_clk_i; the fixed-rate clock and
// the external count pin arrive asynchronously and are synchronised here.
//
// Notes on behaviour
// - Wrap after modulo match sets overflow flag
// - Flag clears on read-while-set then write 0
// - Counter clear or modulo write clears flag
// - Interrupt request when enable and flag set
// - Reset clears interrupt enable; clear flag first
// - Counter-clear bit zeroes count, reads 0
// - Writing 0 to counter-clear does nothing
// - Halt bit freezes count; resume from there
// - Reset sets halt bit
// - Unused bits read as zero
// - Source select: bus, fixed, pin fall, rise
// - Source change keeps current count
// - Reset selects the bus clock
// - Prescale divides by two to power code
// - Codes above eight divide by 256
// - Prescale change keeps current count
// - Reset sets prescale to divide by one
// - Exactly four 8-bit registers
// - Count up to modulo, then wrap to zero
// - Modulo zero means free-running; resets to zero
// - Modulo write zeroes count, clears flag
// - Overflow between read and write keeps flag
//
// Chosen here: the placing of the registers and the strobed register port.
`include "modulo_timer_consts.vh"
`timescale 1ns/1ps
module modulo_timer_top (
   // Clock and reset
   input  wire       ref_clk_i,
   input  wire       rst_i,
   // Register port
   input  wire [3:0] addr_i,
   input  wire [7:0] wdata_i,
   input  wire       wr_i,
   input  wire       rd_i,
   output reg  [7:0] rdata_o,
   // Clock sources
   input  wire       fixed_rate_clock_i,
   input  wire       external_count_input_i,
   // Interrupt request
   output reg        irq_o
);

   // ----------------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------------
   reg        overflow_flag;
   reg        overflow_irq_enable;
   reg        counter_halt;
   reg  [1:0] source_select;
   reg  [3:0] prescale_select;
   reg  [7:0] count_value;
   reg  [7:0] modulo_value;
   // Set by a status read that saw the flag; arms the clearing write
   reg        clear_armed;

   wire wr_sc  = wr_i && (addr_i == `MODULO_TIMER_OFS_STATUS_CTRL);
   wire wr_clk = wr_i && (addr_i == `MODULO_TIMER_OFS_CLOCK_CFG);
   wire wr_mod = wr_i && (addr_i == `MODULO_TIMER_OFS_MODULO);
   wire rd_sc  = rd_i && (addr_i == `MODULO_TIMER_OFS_STATUS_CTRL);

   // ----------------------------------------------------------------------
   // Clock source selection
   // ----------------------------------------------------------------------
   wire fixed_rise;
   wire ext_rise;
   wire ext_fall;

   modulo_timer_edge_sync u_fixed_sync (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .pin_i     (fixed_rate_clock_i),
      .rise_o    (fixed_rise),
      .fall_o    ()
   );

   modulo_timer_edge_sync u_ext_sync (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .pin_i     (external_count_input_i),
      .rise_o    (ext_rise),
      .fall_o    (ext_fall)
   );

   reg src_tick;
   always @* begin
      case (source_select)
         `MODULO_TIMER_SRC_BUS:      src_tick = 1'b1;
         `MODULO_TIMER_SRC_FIXED:    src_tick = fixed_rise;
         `MODULO_TIMER_SRC_EXT_FALL: src_tick = ext_fall;
         `MODULO_TIMER_SRC_EXT_RISE: src_tick = ext_rise;
         default:            src_tick = 1'b1;
      endcase
   end

   wire count_tick;

   modulo_timer_prescaler u_prescaler (
      .ref_clk_i  (ref_clk_i),
      .rst_i      (rst_i),
      .run_i      (~counter_halt),
      .sel_i      (prescale_select),
      .src_tick_i (src_tick),
      .tick_o     (count_tick)
   );

   // ----------------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------------
   // Wrap at the modulo value, or past 0xff when modulo is zero
   wire at_limit = (modulo_value == 8'h00) ? (count_value == 8'hff) :
                                             (count_value == modulo_value);
   wire overflow = count_tick && at_limit;
   wire cnt_clear = wr_sc && wdata_i[`MODULO_TIMER_BIT_CNT_CLEAR];

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         count_value <= `MODULO_TIMER_RST_COUNT;
      end else if (cnt_clear || wr_mod) begin
         count_value <= 8'h00;
      end else if (count_tick) begin
         // Source and ratio changes never reach here, so count carries on
         count_value <= at_limit ? 8'h00 : count_value + 8'h01;
      end
   end

   // ----------------------------------------------------------------------
   // Overflow flag and its two-step clear
   // ----------------------------------------------------------------------
   wire flag_wr_zero = wr_sc && !wdata_i[`MODULO_TIMER_BIT_OVF_FLAG] && clear_armed;

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         overflow_flag <= 1'b0;
         clear_armed   <= 1'b0;
      end else begin
         // A fresh overflow wins over any clear and disarms the sequence
         if (overflow) begin
            overflow_flag <= 1'b1;
         end else if (cnt_clear || wr_mod) begin
            overflow_flag <= 1'b0;
         end else if (flag_wr_zero) begin
            overflow_flag <= 1'b0;
         end
         if (overflow || cnt_clear || wr_mod || wr_sc) begin
            clear_armed <= 1'b0;
         end else if (rd_sc && overflow_flag) begin
            clear_armed <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         overflow_irq_enable <= `MODULO_TIMER_RST_IRQ_EN;
         counter_halt        <= `MODULO_TIMER_RST_HALT;
         source_select       <= `MODULO_TIMER_RST_SRC;
         prescale_select     <= `MODULO_TIMER_RST_PS;
         modulo_value        <= `MODULO_TIMER_RST_MODULO;
      end else begin
         if (wr_sc) begin
            overflow_irq_enable <= wdata_i[`MODULO_TIMER_BIT_OVF_IRQ_EN];
            counter_halt        <= wdata_i[`MODULO_TIMER_BIT_CNT_HALT];
         end
         if (wr_clk) begin
            source_select   <= wdata_i[`MODULO_TIMER_SRC_MSB:`MODULO_TIMER_SRC_LSB];
            prescale_select <= wdata_i[`MODULO_TIMER_PS_MSB:`MODULO_TIMER_PS_LSB];
         end
         if (wr_mod) begin
            modulo_value <= wdata_i;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Read port and interrupt
   // ----------------------------------------------------------------------
   reg [7:0] next_rdata;
   always @* begin
      next_rdata = 8'h00;
      case (addr_i)
         `MODULO_TIMER_OFS_STATUS_CTRL:
            next_rdata = {overflow_flag, overflow_irq_enable, 1'b0, counter_halt, 4'h0};
         `MODULO_TIMER_OFS_CLOCK_CFG:
            next_rdata = {2'h0, source_select, prescale_select};
         `MODULO_TIMER_OFS_COUNT_VALUE:
            next_rdata = count_value;
         `MODULO_TIMER_OFS_MODULO:
            next_rdata = modulo_value;
         default:
            next_rdata = 8'h00;
      endcase
   end

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
         irq_o   <= 1'b0;
      end else begin
         rdata_o <= rd_i ? next_rdata : 8'h00;
         irq_o   <= overflow_irq_enable && overflow_flag;
      end
   end

endmodule

// [dv/mt8_checker.sv]
// Checker for the timer top: read data, unused bits, interrupt level.
// Assumes it is bound onto modulo_timer_top and sees its ports only.
`timescale 1ns/1ps
module mt8_checker (
   // Clock and reset
   input wire       ref_clk_i,
   input wire       rst_i,
   // Register port
   input wire [3:0] addr_i,
   input wire [7:0] wdata_i,
   input wire       wr_i,
   input wire       rd_i,
   input wire [7:0] rdata_o,
   // Interrupt
   input wire       irq_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // --------------------------------------------------------------
   // Properties
   // --------------------------------------------------------------
   sequence s_rd(a); rd_i && addr_i == a; endsequence
   sequence s_wsc; wr_i && addr_i == 4'h0; endsequence
   sequence s_wlim; wr_i && addr_i == 4'h3; endsequence
   property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
   property p_sc0; s_rd(4'h0) |=> !rdata_o[5] && rdata_o[3:0] == 4'h0; endproperty
   property p_cfg0; s_rd(4'h1) |=> rdata_o[7:6] == 2'h0; endproperty
   property p_unmap; rd_i && addr_i > 4'h3 |=> rdata_o == 8'h00; endproperty
   property p_irq; s_rd(4'h0) |=> irq_o == (rdata_o[7] & rdata_o[6]); endproperty
   // Interrupt lags the enable by one edge, so look two edges on
   property p_irq_off; s_wsc ##0 !wdata_i[6] |-> ##2 !irq_o; endproperty
   property p_wlim; s_wlim |-> ##2 !irq_o; endproperty
   property p_wlim_cnt; s_wlim ##1 s_rd(4'h2) |=> rdata_o == 8'h00; endproperty
   property p_rst; $fell(rst_i) |-> !irq_o ##1 !irq_o; endproperty
   a_idle: assert property (p_idle) else $error("idle read data");
   a_sc0: assert property (p_sc0) else $error("status unused bits");
   a_cfg0: assert property (p_cfg0) else $error("config unused bits");
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   a_irq: assert property (p_irq) else $error("irq level");
   a_irq_off: assert property (p_irq_off) else $error("irq after disable");
   a_wlim: assert property (p_wlim) else $error("flag after limit write");
   a_wlim_cnt: assert property (p_wlim_cnt) else $error("count after limit write");
   a_rst: assert property (p_rst) else $error("irq after reset");
endmodule

// [dv/mt8_bench.sv]
// Bench for the timer: registers, counting, flag, interrupt, sources.
// Assumes modulo_timer_top on 100 MHz; one pin feeds both count inputs.
`timescale 1ns/1ps
module mt8_bench;
   reg        ref_clk_i;
   reg        rst_i;
   reg        wr_i;
   reg        rd_i;
   reg        pin;
   reg  [3:0] addr_i;
   reg  [7:0] wdata_i;
   wire [7:0] rdata_o;
   wire       irq_o;
   integer    n_fail;
   integer    checked;
   integer    i;
   integer    j;
   modulo_timer_top DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .fixed_rate_clock_i(pin), .external_count_input_i(pin), .irq_o(irq_o));
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // --------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------
   task end_of_test;
      begin
         $display("checked %0d n_fail %0d", checked, n_fail);
         if (n_fail == 0 && checked > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input [7:0] g, input [7:0] lo, input [7:0] hi);
      begin
         checked = checked + 1;
         if ((g >= lo && g <= hi) !== 1'b1) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %0t got %h exp %h..%h", $time, g, lo, hi);
         end
      end
   endtask
   // A write right after a write waits one edge so the strobe is set once
   task wr(input [3:0] a, input [7:0] v);
      begin
         if (wr_i === 1'b1)
            @(posedge ref_clk_i);
         wr_i    <= 1'b1;
         addr_i  <= a;
         wdata_i <= v;
         @(posedge ref_clk_i);
         wr_i <= 1'b0;
      end
   endtask
   task rc(input [3:0] a, input [7:0] lo, input [7:0] hi);
      begin
         rd_i   <= 1'b1;
         addr_i <= a;
         @(posedge ref_clk_i);
         rd_i <= 1'b0;
         @(negedge ref_clk_i);
         chk(rdata_o, lo, hi);
         @(posedge ref_clk_i);
      end
   endtask
   // The interrupt output is registered one edge after the flag it follows
   task iq(input [7:0] v);
      begin
         @(posedge ref_clk_i);
         @(negedge ref_clk_i);
         chk({7'h00, irq_o}, v, v);
         @(posedge ref_clk_i);
      end
   endtask
   // --------------------------------------------------------------
   // Tests
   // --------------------------------------------------------------
   initial begin
      rst_i   = 1'b1;
      wr_i    = 1'b0;
      rd_i    = 1'b0;
      pin     = 1'b0;
      addr_i  = 4'h0;
      wdata_i = 8'h00;
      n_fail  = 0;
      checked = 0;
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      rc(4'h0, 8'h10, 8'h10);
      rc(4'h1, 8'h00, 8'h00);
      rc(4'h3, 8'h00, 8'h00);
      wr(4'h5, 8'hff);
      rc(4'h5, 8'h00, 8'h00);
      wr(4'h0, 8'h00);
      repeat (6) @(posedge ref_clk_i);
      wr(4'h0, 8'h10);
      wr(4'h2, 8'h55);
      wr(4'h0, 8'h10);
      rc(4'h2, 8'h07, 8'h07);
      wr(4'h0, 8'h00);
      wr(4'h0, 8'h10);
      rc(4'h2, 8'h09, 8'h09);
      wr(4'h3, 8'h20);
      rc(4'h2, 8'h00, 8'h00);
      for (i = 0; i < 11; i = i + 1) begin
         j = (i == 10) ? 15 : i;
         wr(4'h0, 8'h30);
         wr(4'h1, j[7:0]);
         wr(4'h0, 8'h00);
         repeat ((4 << (j > 8 ? 8 : j)) - 1) @(posedge ref_clk_i);
         wr(4'h0, 8'h10);
         rc(4'h2, 8'h04, 8'h04);
      end
      wr(4'h1, 8'h00);
      wr(4'h3, 8'h05);
      wr(4'h0, 8'h00);
      repeat (5) @(posedge ref_clk_i);
      wr(4'h0, 8'h10);
      rc(4'h2, 8'h00, 8'h00);
      wr(4'h0, 8'h10);
      rc(4'h0, 8'h90, 8'h90);
      wr(4'h0, 8'h10);
      rc(4'h0, 8'h10, 8'h10);
      wr(4'h0, 8'h50);
      wr(4'h0, 8'h40);
      repeat (5) @(posedge ref_clk_i);
      wr(4'h0, 8'h50);
      iq(8'h01);
      rc(4'h0, 8'hd0, 8'hd0);
      wr(4'h0, 8'h70);
      rc(4'h0, 8'h50, 8'h50);
      iq(8'h00);
      // Second overflow between the arming read and the clearing write
      wr(4'h0, 8'h00);
      repeat (6) @(posedge ref_clk_i);
      rc(4'h0, 8'h80, 8'h80);
      repeat (4) @(posedge ref_clk_i);
      wr(4'h0, 8'h10);
      rc(4'h0, 8'h90, 8'h90);
      // Four rising and three falling pin edges per pass
      for (i = 1; i < 4; i = i + 1) begin
         pin <= 1'b0;
         wr(4'h0, 8'h30);
         wr(4'h1, {2'h0, i[1:0], 4'h0});
         wr(4'h0, 8'h00);
         for (j = 0; j < 7; j = j + 1) begin
            pin <= ~pin;
            repeat (4) @(posedge ref_clk_i);
         end
         repeat (4) @(posedge ref_clk_i);
         wr(4'h0, 8'h10);
         rc(4'h2, (i == 2) ? 8'h03 : 8'h04, (i == 2) ? 8'h03 : 8'h04);
      end
      // Source change while running; the pin is quiet, so the count must stay
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h10);
      wr(4'h0, 8'h10);
      rc(4'h2, 8'h04, 8'h04);
      // Reset in mid-run returns every register to its reset value
      wr(4'h1, 8'h3f);
      wr(4'h0, 8'h40);
      rst_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      rc(4'h0, 8'h10, 8'h10);
      rc(4'h1, 8'h00, 8'h00);
      rc(4'h3, 8'h00, 8'h00);
      rc(4'h2, 8'h00, 8'h00);
      end_of_test;
   end
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      n_fail = n_fail + 1;
      end_of_test;
   end
endmodule
bind modulo_timer_top mt8_checker u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
